// *** rtl/gpppc_pkg.sv ***
/*
  gpppc_pkg: register map, field positions, reset values and carrier types
  for the port pair pin control block.
  assumes a 32-bit Avalon-MM slave with word addressing in bytes.
*/
package gpppc_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int          gpppc_addr_w   = 8;
  localparam int          gpppc_b_pins   = 4;
  localparam int          gpppc_a_pins   = 8;

  // ------------------------------------------------------------
  // port b register offsets
  // ------------------------------------------------------------
  localparam logic [7:0]  gpppc_off_b_data   = 8'h00;
  localparam logic [7:0]  gpppc_off_b_oe     = 8'h04;
  localparam logic [7:0]  gpppc_off_b_fs2    = 8'h0c;
  localparam logic [7:0]  gpppc_off_b_fs3    = 8'h10;
  localparam logic [7:0]  gpppc_off_b_pup    = 8'h2c;
  localparam logic [7:0]  gpppc_off_b_ie     = 8'h38;

  // ------------------------------------------------------------
  // port a register offsets
  // ------------------------------------------------------------
  localparam logic [7:0]  gpppc_off_a_fs3    = 8'h40;
  localparam logic [7:0]  gpppc_off_a_pup    = 8'h44;
  localparam logic [7:0]  gpppc_off_a_ie     = 8'h48;

  // ------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------
  localparam logic [1:0]  gpppc_b_fs2_mask   = 2'h3;
  localparam logic [1:0]  gpppc_a_fs3_mask   = 2'h3;
  localparam int          gpppc_a_fs3_lsb    = 6;
  localparam logic [3:0]  gpppc_b_reset      = 4'h0;
  localparam logic [7:0]  gpppc_a_reset      = 8'h00;
  localparam logic [31:0] gpppc_unmapped_rd  = 32'h00000000;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] data;
    logic [3:0] oe;
    logic [1:0] fs2;
    logic [3:0] fs3;
    logic [3:0] pup;
    logic [3:0] ie;
  } gpppc_b_regs_type;

  typedef struct packed {
    logic [1:0] fs3;
    logic [7:0] pup;
    logic [7:0] ie;
  } gpppc_a_regs_type;

  typedef struct packed {
    logic external_interrupt_three;
    logic external_interrupt_two;
    logic timer_six_capture_input_one;
    logic timer_six_capture_input_zero;
    logic timer_one_capture_input_one;
    logic timer_one_capture_input_zero;
    logic timer_zero_capture_input_one;
    logic timer_zero_capture_input_zero;
  } gpppc_periph_type;

endpackage

// *** rtl/gpppc_top.sv ***
/*
  gpppc_top: register slave and pin control for a 4-bit port (b) and the
  timer select, pull-up and input enable of an 8-bit port (a).
  holds the bus handshake, one flip-flop register per control field,
  the data read view, the routing of enabled pin levels to the interrupt
  and timer capture inputs, and of raw pin levels to the converter inputs.
  assumes pin inputs synchronous to clk and an Avalon-MM master that holds
  its request until waitrequest is seen low.
  assumes the pad cells take the output enable high as drive, and that
  software keeps at most one select bit set for any pin.
*/
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - port b has four bidirectional pins
// - direction chosen independently per bit
// - pins route to converter, interrupts, timer
// - reset: all off, plain I/O
// - both select bits zero means plain I/O; interrupt lines still follow enabled inputs
// - enabled input reaches interrupt outside stop
// - data at zero, output enable at four
// - selects 0x0c/0x10, pull-up 0x2c, input 0x38
// - port a bits 7,6 select timer zero
// - port a pull-up bits 7 to 0
// - port a input enable, resets zero
// - port b data bits 3 to 0
// - port b output enable bits 3 to 0
// - port b bits 1,0 select interrupts three,two; the interrupt routing ignores these bits
// - port b timer six and one selects
// - port b pull-up bits 3 to 0
// - port b input enable bits 3 to 0

module gpppc_top
  import gpppc_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic [gpppc_addr_w-1:0]  avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  input  wire logic                     stop_mode,
  input  wire logic [3:0]               port_b_pin_in,
  output logic [3:0]                    port_b_pin_out,
  output logic [3:0]                    port_b_pin_oe,
  output logic [3:0]                    port_b_pullup_on,
  output logic [3:0]                    port_b_input_buffer_on,
  output logic [3:0]                    port_b_analog_level,
  input  wire logic [7:0]               port_a_pin_in,
  output logic [7:0]                    port_a_pullup_on,
  output logic [7:0]                    port_a_input_buffer_on,
  output gpppc_periph_type              periph
);

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  gpppc_b_regs_type  regs_b;
  gpppc_a_regs_type  regs_a;
  logic              ack;
  logic              wr_en;
  logic [31:0]       next_readdata;
  logic [3:0]        b_data_view;
  logic [3:0]        b_data;
  logic [3:0]        b_oe;
  logic [1:0]        b_fs2;
  logic [3:0]        b_fs3;
  logic [3:0]        b_pup;
  logic [3:0]        b_ie;
  logic [1:0]        a_fs3;
  logic [7:0]        a_pup;
  logic [7:0]        a_ie;

  // byte lane 0 carries every implemented field
  function automatic logic hit(input logic [7:0] off);
    hit = wr_en && (avs_address == off) && avs_byteenable[0];
  endfunction

  // ----------------------------------------------------------
  // bus handshake: one wait cycle then answer
  // ----------------------------------------------------------
  typedef enum {
    bus_idle,
    bus_answer
  } gpppc_bus_state_type;

  gpppc_bus_state_type bus_state;
  gpppc_bus_state_type next_bus_state;

  // every request, mapped or not, gets the same single wait
  always_comb
  begin
    next_bus_state = bus_state;
    case (bus_state)
      bus_idle:
        if (avs_read || avs_write)
          next_bus_state = bus_answer;
      bus_answer:
        next_bus_state = bus_idle;
      default:
        next_bus_state = bus_idle;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      bus_state <= bus_idle;
    else
      bus_state <= next_bus_state;
  end

  assign ack             = (bus_state == bus_answer);
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign wr_en           = avs_write && !ack;

  // ----------------------------------------------------------
  // port b registers
  // ----------------------------------------------------------
  // data latch
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      b_data <= gpppc_b_reset;
    else if (hit(gpppc_off_b_data))
      b_data <= avs_writedata[3:0];
  end

  // output enables
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      b_oe <= gpppc_b_reset;
    else if (hit(gpppc_off_b_oe))
      b_oe <= avs_writedata[3:0];
  end

  // interrupt selects
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      b_fs2 <= gpppc_b_reset[1:0];
    else if (hit(gpppc_off_b_fs2))
      b_fs2 <= avs_writedata[1:0] & gpppc_b_fs2_mask;
  end

  // timer selects
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      b_fs3 <= gpppc_b_reset;
    else if (hit(gpppc_off_b_fs3))
      b_fs3 <= avs_writedata[3:0];
  end

  // pull-up enables
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      b_pup <= gpppc_b_reset;
    else if (hit(gpppc_off_b_pup))
      b_pup <= avs_writedata[3:0];
  end

  // input enables
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      b_ie <= gpppc_b_reset;
    else if (hit(gpppc_off_b_ie))
      b_ie <= avs_writedata[3:0];
  end

  // ----------------------------------------------------------
  // port a registers
  // ----------------------------------------------------------
  // timer selects on bits 7 and 6
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      a_fs3 <= gpppc_a_reset[1:0];
    else if (hit(gpppc_off_a_fs3))
      a_fs3 <= avs_writedata[gpppc_a_fs3_lsb +: 2] & gpppc_a_fs3_mask;
  end

  // pull-up enables
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      a_pup <= gpppc_a_reset;
    else if (hit(gpppc_off_a_pup))
      a_pup <= avs_writedata[7:0];
  end

  // input enables
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      a_ie <= gpppc_a_reset;
    else if (hit(gpppc_off_a_ie))
      a_ie <= avs_writedata[7:0];
  end

  // ----------------------------------------------------------
  // register views
  // ----------------------------------------------------------
  // port b view
  assign regs_b = '{
    data: b_data,
    oe:   b_oe,
    fs2:  b_fs2,
    fs3:  b_fs3,
    pup:  b_pup,
    ie:   b_ie
  };

  // port a view
  assign regs_a = '{
    fs3: a_fs3,
    pup: a_pup,
    ie:  a_ie
  };

  // ----------------------------------------------------------
  // read path
  // ----------------------------------------------------------
  generate
    for (genvar i = 0; i < gpppc_b_pins; i++)
    begin : g_view
      assign b_data_view[i] = regs_b.ie[i] ? port_b_pin_in[i] :
                              (regs_b.oe[i] & regs_b.data[i]);
    end
  endgenerate

  always_comb
  begin
    next_readdata = gpppc_unmapped_rd;
    case (avs_address)
      gpppc_off_b_data: next_readdata[3:0] = b_data_view;
      gpppc_off_b_oe:   next_readdata[3:0] = regs_b.oe;
      gpppc_off_b_fs2:  next_readdata[1:0] = regs_b.fs2;
      gpppc_off_b_fs3:  next_readdata[3:0] = regs_b.fs3;
      gpppc_off_b_pup:  next_readdata[3:0] = regs_b.pup;
      gpppc_off_b_ie:   next_readdata[3:0] = regs_b.ie;
      gpppc_off_a_fs3:  next_readdata[gpppc_a_fs3_lsb +: 2] = regs_a.fs3;
      gpppc_off_a_pup:  next_readdata[7:0] = regs_a.pup;
      gpppc_off_a_ie:   next_readdata[7:0] = regs_a.ie;
      default:          next_readdata = gpppc_unmapped_rd;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      avs_readdata <= gpppc_unmapped_rd;
    else if (avs_read && !ack)
      avs_readdata <= next_readdata;
  end

  // ----------------------------------------------------------
  // pin and peripheral routing
  // ----------------------------------------------------------
  logic [3:0] b_in;
  logic [7:0] a_in;

  always_comb
  begin
    b_in = port_b_pin_in & regs_b.ie & {4{!stop_mode}};
    a_in = port_a_pin_in & regs_a.ie & {8{!stop_mode}};
  end

  // port b pad controls, one clock behind the registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      port_b_pin_out         <= gpppc_b_reset;
      port_b_pin_oe          <= gpppc_b_reset;
      port_b_pullup_on       <= gpppc_b_reset;
      port_b_input_buffer_on <= gpppc_b_reset;
    end
    else
    begin
      port_b_pin_out         <= regs_b.data;
      port_b_pin_oe          <= regs_b.oe;
      port_b_pullup_on       <= regs_b.pup;
      port_b_input_buffer_on <= regs_b.ie;
    end
  end

  // converter path takes the raw pin level
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      port_b_analog_level <= gpppc_b_reset;
    else
      port_b_analog_level <= port_b_pin_in;
  end

  // port a pad controls
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      port_a_pullup_on       <= gpppc_a_reset;
      port_a_input_buffer_on <= gpppc_a_reset;
    end
    else
    begin
      port_a_pullup_on       <= regs_a.pup;
      port_a_input_buffer_on <= regs_a.ie;
    end
  end

  // peripheral inputs
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      periph <= '0;
    else
    begin
      // interrupt lines follow enabled inputs whatever the selects say
      periph.external_interrupt_three      <= b_in[1];
      periph.external_interrupt_two        <= b_in[0];
      // timer captures also need their select bit
      periph.timer_six_capture_input_one   <= b_in[3] & regs_b.fs3[3];
      periph.timer_six_capture_input_zero  <= b_in[2] & regs_b.fs3[2];
      periph.timer_one_capture_input_one   <= b_in[1] & regs_b.fs3[1];
      periph.timer_one_capture_input_zero  <= b_in[0] & regs_b.fs3[0];
      periph.timer_zero_capture_input_one  <= a_in[7] & regs_a.fs3[1];
      periph.timer_zero_capture_input_zero <= a_in[6] & regs_a.fs3[0];
    end
  end

endmodule // gpppc_top

`default_nettype wire

// *** bench/gpppc_pins.sv ***
/*
  gpppc_pins: pin model for port b, the far side of the block.
  assumes pin_b feeds port_b_pin_in of the top.
*/
`timescale 1ns/100ps
`default_nettype none
module gpppc_pins
(
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] ext_b,
  output logic [3:0]      pin_b
);
  // driven bits show the latch, others the outside level
  assign pin_b = (pin_oe & pin_out) | (~pin_oe & ext_b);
endmodule // gpppc_pins
`default_nettype wire

// *** bench/gpppc_top_assertions.sv ***
/*
  gpppc_top_assertions: port checks for gpppc_top.
  assumes binding onto gpppc_top, all ports matched by name.
*/
`timescale 1ns/100ps
`default_nettype none
module gpppc_top_assertions
  import gpppc_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic [gpppc_addr_w-1:0] avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [31:0]             avs_readdata,
  input  wire logic                    avs_waitrequest,
  input  wire logic                    stop_mode,
  input  wire logic [3:0]              port_b_pin_in,
  input  wire logic [3:0]              port_b_pin_oe,
  input  wire logic [3:0]              port_b_input_buffer_on,
  input  wire logic [3:0]              port_b_analog_level,
  input  wire gpppc_periph_type        periph
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // handshake steps, register and pin checks
  // ----------------------------------------
  sequence oe_taken;
    avs_write && avs_waitrequest && avs_address == gpppc_off_b_oe ##1 !avs_waitrequest;
  endsequence
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");
  idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  oe_write_a: assert property (oe_taken |=> port_b_pin_oe == $past(avs_writedata[3:0], 2))
    else $error("output enable not written");
  rd_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  stop_block_a: assert property (stop_mode |=> periph == 8'h00)
    else $error("input passed in stop");
  int_three_a: assert property (!stop_mode |=> periph.external_interrupt_three ==
    ($past(port_b_pin_in[1]) & port_b_input_buffer_on[1]))
    else $error("interrupt three wrong");
  int_two_a: assert property (!stop_mode |=> periph.external_interrupt_two ==
    ($past(port_b_pin_in[0]) & port_b_input_buffer_on[0]))
    else $error("interrupt two wrong");
  analog_path_a: assert property ($past(rst_b) |->
    port_b_analog_level == $past(port_b_pin_in))
    else $error("converter level wrong");
endmodule // gpppc_top_assertions
bind gpppc_top gpppc_top_assertions chk_u (.*);
`default_nettype wire

// *** bench/testbench.sv ***
/*
  testbench: register and pin tests for gpppc_top over Avalon-MM.
  assumes the pin model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench
  import gpppc_pkg::*;
;
  logic             clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, stop_mode = 1'b0;
  logic [7:0]       adr = 8'h00, pins_a = 8'h00, a_pup, a_ie;
  logic [31:0]      wdat = 32'h0, rdat;
  logic [3:0]       ext_b = 4'h0, b_in, b_out, b_oe, b_pup, b_ie, b_an;
  logic             wait_r;
  gpppc_periph_type periph;
  int               bad_count = 0, num_checks = 0;
  logic [7:0]  offs [8] = '{8'h04, 8'h0c, 8'h10, 8'h2c, 8'h38, 8'h40, 8'h44, 8'h48};
  logic [31:0] wv [8] = '{'1, '1, 32'hfffffffc, '1, '1, '1, '1, '1};
  logic [31:0] ev [8] = '{32'hf, 32'h3, 32'hc, 32'hf, 32'hf, 32'hc0, 32'hff, 32'hff};
  always #2 clk = ~clk;
  gpppc_pins pins_u (.pin_out(b_out), .pin_oe(b_oe), .ext_b(ext_b), .pin_b(b_in));
  gpppc_top dut_u (.clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
    .avs_waitrequest(wait_r), .stop_mode(stop_mode), .port_b_pin_in(b_in),
    .port_b_pin_out(b_out), .port_b_pin_oe(b_oe), .port_b_pullup_on(b_pup),
    .port_b_input_buffer_on(b_ie), .port_b_analog_level(b_an), .port_a_pin_in(pins_a),
    .port_a_pullup_on(a_pup), .port_a_input_buffer_on(a_ie), .periph(periph));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wait_r !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #200000;
    bad_count++;
    close_out;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    chk({b_out, b_oe, b_pup, b_ie, a_pup, a_ie}, 32'h0);
    rchk(8'h00, 32'h0);
    for (int i = 0; i < 8; i++) rchk(offs[i], 32'h0);
    for (int i = 0; i < 8; i++) acc(1'b1, offs[i], wv[i]);
    for (int i = 0; i < 8; i++) rchk(offs[i], ev[i]);
    chk({b_oe, b_pup, b_ie, a_pup, a_ie}, {12'hfff, 16'hffff});
    acc(1'b1, 8'h80, '1);
    rchk(8'h80, 32'h0);
    acc(1'b1, 8'h00, 32'hfffffffa);
    rchk(8'h00, 32'ha);
    chk(b_out, 4'ha);
    acc(1'b1, 8'h38, 32'h0);
    acc(1'b1, 8'h04, 32'h3);
    rchk(8'h00, 32'h2);
    acc(1'b1, 8'h04, 32'h0);
    rchk(8'h00, 32'h0);
    ext_b <= 4'h3;
    pins_a <= 8'hc0;
    acc(1'b1, 8'h38, 32'hf);
    rchk(8'h00, 32'h3);
    acc(1'b1, 8'h0c, 32'h0);
    acc(1'b1, 8'h10, 32'h0);
    repeat (3) @(posedge clk);
    chk(periph, 8'hc3);
    acc(1'b1, 8'h10, 32'hf);
    repeat (3) @(posedge clk);
    chk(periph, 8'hcf);
    ext_b <= 4'hc;
    repeat (3) @(posedge clk);
    chk(periph, 8'h33);
    stop_mode <= 1'b1;
    repeat (3) @(posedge clk);
    chk(periph, 8'h00);
    stop_mode <= 1'b0;
    acc(1'b1, 8'h38, 32'h0);
    repeat (3) @(posedge clk);
    chk(periph, 8'h03);
    acc(1'b1, 8'h2c, 32'h0);
    repeat (2) @(posedge clk);
    chk({b_pup, b_ie, b_an}, 12'h00c);
    close_out;
  end
endmodule // testbench
`default_nettype wire
